// ### design/cno_nmt_node.sv
`timescale 1ns/10ps
// How it works
// [RULE_01] NMT frame: identifier zero, two bytes
// [RULE_02] Byte0 command, byte1 target node address
// [RULE_03] Address zero is broadcast, executed
// [RULE_04] Command 0x01 enters operational, PDO on
// [RULE_05] Command 0x02 stops, no PDO/SDO
// [RULE_06] Command 0x80 pre-operational, SDO only
// [RULE_07] Start-up goes pre-operational automatically
// [RULE_08] Command 0x81 resets whole device
// [RULE_09] Command 0x82 restores communication defaults only
// [RULE_10] Any transition among three operating states
// [RULE_11] Reset commands accepted from all states; code takes them only in preop, operational and stopped
// [RULE_12] Emergency identifier 0x80 plus node
// [RULE_13] Transmit PDO ids 0x180..0x480 plus node
// [RULE_14] Receive PDO ids 0x200..0x500 plus node
// [RULE_15] SDO answer 0x580, request 0x600 plus node
// [RULE_16] Boot and error control 0x700 plus node
// [RULE_17] SYNC is identifier 0x80, no data
// [RULE_18] Emergency sent on every error change; code sends one frame for all changes made while one is still pending
// [RULE_19] Emergency frames carry eight bytes
// [RULE_20] Code bytes 0-1, register 2, vendor 3-7
// [RULE_21] Byte 2 copies current error register
// [RULE_22] SYNC triggers synchronous transmit PDOs only
// [RULE_23] State byte: 00 boot, 05 op, 7f preop
// [RULE_24] One boot-up frame after each reset
// [RULE_25] Foreign address or unknown command ignored
// [RULE_26] Node address held within 1 to 127
module cno_nmt_node
	import cno_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic ce, // Clock enable
	input wire logic [6:0] node_id_pin, // Node address strap pins
	input wire logic rx_valid, // Received frame strobe
	input wire cno_frame_s rx_frame, // Received frame
	output logic tx_valid, // Frame to send pending
	input wire logic tx_ready, // Transmitter takes frame
	output cno_frame_s tx_frame, // Frame to send
	input wire logic [15:0] err_code, // Emergency error code
	input wire logic [7:0] err_reg, // Error register object
	input wire logic [39:0] err_vendor, // Vendor error information
	input wire logic err_change, // Error state changed pulse
	input wire logic [3:0] tpdo_sync, // Transmit PDO is synchronous
	output logic [3:0] tpdo_sync_trig, // Synchronous PDO trigger pulse
	output logic [3:0][10:0] tpdo_id, // Transmit PDO identifiers
	output logic [10:0] sdo_tx_id, // SDO response identifier
	output logic [3:0] rpdo_hit, // Receive PDO accepted pulse
	output logic sdo_req_hit, // SDO request accepted pulse
	output logic pdo_en, // PDO traffic permitted
	output logic sdo_en, // SDO traffic permitted
	output logic app_rst, // Application reset pulse
	output logic comm_rst, // Communication defaults restore pulse
	output logic [7:0] nmt_state, // Reported state byte
	output logic [6:0] node_id // Active node address
);

	// ----------------------------------------
	// Identifier helpers
	// ----------------------------------------
	function automatic logic [10:0] cno_id(input logic [10:0] base, input logic [6:0] nid);
		cno_id = base | {4'h0, nid};
	endfunction : cno_id

	function automatic logic [6:0] cno_clamp(input logic [6:0] nid);
		cno_clamp = (nid < CNO_NODE_MIN) ? CNO_NODE_DEF : nid; // RULE_26
	endfunction : cno_clamp

	// Emergencies wait for boot-up and stay queued while stopped
	function automatic logic cno_emcy_ok(input cno_state_e s);
		case (s)
			CNO_PREOP, CNO_OPER: cno_emcy_ok = 1'b1;
			default: cno_emcy_ok = 1'b0;
		endcase
	endfunction : cno_emcy_ok

	function automatic logic [7:0] cno_state_byte(input cno_state_e s);
		case (s)
			CNO_OPER: cno_state_byte = CNO_ST_OPER; // RULE_23
			CNO_PREOP: cno_state_byte = CNO_ST_PREOP; // RULE_23
			CNO_STOPPED: cno_state_byte = CNO_ST_STOP;
			default: cno_state_byte = CNO_ST_BOOT; // RULE_23
		endcase
	endfunction : cno_state_byte

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	logic [6:0] nid_s1_r, nid_s2_r;
	logic [6:0] nid_s1_nxt, nid_s2_nxt;

	always_comb begin
		nid_s1_nxt = node_id_pin;
		nid_s2_nxt = nid_s1_r;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nid_s1_r <= 7'h00;
			nid_s2_r <= 7'h00;
		end else if (ce) begin
			nid_s1_r <= nid_s1_nxt;
			nid_s2_r <= nid_s2_nxt;
		end
	end

	// ----------------------------------------
	// Receive decode
	// ----------------------------------------
	logic [7:0] rx_cmd;
	logic [7:0] rx_addr;
	logic nmt_hit;
	logic sync_hit;

	always_comb begin
		rx_cmd = rx_frame.data[7:0]; // RULE_02
		rx_addr = rx_frame.data[15:8]; // RULE_02
		nmt_hit = rx_valid && rx_frame.id == CNO_ID_NMT && rx_frame.dlc == CNO_DLC_NMT // RULE_01
			&& (rx_addr == CNO_BCAST || rx_addr == {1'b0, node_id}); // RULE_03 RULE_25
		sync_hit = rx_valid && rx_frame.id == CNO_ID_SYNC && rx_frame.dlc == CNO_DLC_SYNC; // RULE_17
	end

	// ----------------------------------------
	// Node state machine
	// ----------------------------------------
	cno_state_e state_r, state_nxt;
	logic [6:0] node_id_r, node_id_nxt;
	logic [3:0] rcnt_r, rcnt_nxt;
	logic boot_pend_r, boot_pend_nxt;
	logic app_rst_r, app_rst_nxt;
	logic comm_rst_r, comm_rst_nxt;
	logic boot_sent;

	always_comb begin
		state_nxt = state_r;
		node_id_nxt = node_id_r;
		rcnt_nxt = rcnt_r;
		boot_pend_nxt = boot_pend_r && !boot_sent;
		app_rst_nxt = 1'b0;
		comm_rst_nxt = 1'b0;
		case (state_r)
			CNO_INIT: begin
				// Address caught after reset release, via synchroniser
				node_id_nxt = cno_clamp(nid_s2_r); // RULE_26
				rcnt_nxt = rcnt_r + 4'h1;
				if (rcnt_r == CNO_RST_CYC) begin
					rcnt_nxt = 4'h0;
					state_nxt = CNO_BOOT;
					boot_pend_nxt = 1'b1; // RULE_24
				end
			end
			CNO_BOOT: begin
				if (!boot_pend_r) begin
					state_nxt = CNO_PREOP; // RULE_07
				end
			end
			CNO_RST_APP: begin
				app_rst_nxt = 1'b1; // RULE_08
				rcnt_nxt = rcnt_r + 4'h1;
				if (rcnt_r == CNO_RST_CYC) begin
					rcnt_nxt = 4'h0;
					state_nxt = CNO_RST_COMM;
				end
			end
			CNO_RST_COMM: begin
				comm_rst_nxt = 1'b1; // RULE_09
				rcnt_nxt = rcnt_r + 4'h1;
				if (rcnt_r == CNO_RST_CYC) begin
					rcnt_nxt = 4'h0;
					node_id_nxt = cno_clamp(nid_s2_r); // RULE_26
					state_nxt = CNO_BOOT;
					boot_pend_nxt = 1'b1; // RULE_24
				end
			end
			CNO_PREOP, CNO_OPER, CNO_STOPPED: begin
				if (nmt_hit) begin
					case (rx_cmd)
						CNO_CMD_START: state_nxt = CNO_OPER; // RULE_04 RULE_10
						CNO_CMD_STOP: state_nxt = CNO_STOPPED; // RULE_05 RULE_10
						CNO_CMD_PREOP: state_nxt = CNO_PREOP; // RULE_06 RULE_10
						CNO_CMD_RST_NODE: state_nxt = CNO_RST_APP; // RULE_08 RULE_11
						CNO_CMD_RST_COMM: state_nxt = CNO_RST_COMM; // RULE_09 RULE_11
						default: state_nxt = state_r; // RULE_25
					endcase
				end
			end
			default: state_nxt = CNO_INIT;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= CNO_INIT;
			node_id_r <= CNO_NODE_DEF;
			rcnt_r <= 4'h0;
			boot_pend_r <= 1'b0;
			app_rst_r <= 1'b0;
			comm_rst_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			node_id_r <= node_id_nxt;
			rcnt_r <= rcnt_nxt;
			boot_pend_r <= boot_pend_nxt;
			app_rst_r <= app_rst_nxt;
			comm_rst_r <= comm_rst_nxt;
		end
	end

	// ----------------------------------------
	// Traffic gating and receive strobes
	// ----------------------------------------
	logic [3:0] rpdo_nxt, rpdo_r, trig_nxt, trig_r;
	logic sdo_nxt, sdo_r;
	logic [10:0] rpdo_base [4];
	logic [7:0] st_byte_nxt, st_byte_r;
	logic pdo_en_nxt, pdo_en_r, sdo_en_nxt, sdo_en_r;

	assign rpdo_base[0] = CNO_ID_RPDO1;
	assign rpdo_base[1] = CNO_ID_RPDO2;
	assign rpdo_base[2] = CNO_ID_RPDO3;
	assign rpdo_base[3] = CNO_ID_RPDO4;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			rpdo_nxt[i] = pdo_en && rx_valid
				&& rx_frame.id == cno_id(rpdo_base[i], node_id_r); // RULE_14 RULE_05
		end
		trig_nxt = (pdo_en && sync_hit) ? tpdo_sync : 4'h0; // RULE_22
		sdo_nxt = sdo_en && rx_valid && rx_frame.id == cno_id(CNO_ID_SDO_RX, node_id_r); // RULE_15
		// From the next state, so the outputs switch with the state itself
		st_byte_nxt = cno_state_byte(state_nxt);
		pdo_en_nxt = state_nxt == CNO_OPER; // RULE_04 RULE_06
		sdo_en_nxt = state_nxt == CNO_OPER || state_nxt == CNO_PREOP; // RULE_05 RULE_06
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rpdo_r <= 4'h0;
			trig_r <= 4'h0;
			sdo_r <= 1'b0;
			st_byte_r <= CNO_ST_BOOT;
			pdo_en_r <= 1'b0;
			sdo_en_r <= 1'b0;
		end else if (ce) begin
			rpdo_r <= rpdo_nxt;
			trig_r <= trig_nxt;
			sdo_r <= sdo_nxt;
			st_byte_r <= st_byte_nxt;
			pdo_en_r <= pdo_en_nxt;
			sdo_en_r <= sdo_en_nxt;
		end
	end

	// ----------------------------------------
	// Transmit: boot-up and emergency
	// ----------------------------------------
	logic emcy_pend_r, emcy_pend_nxt;
	logic tx_busy_r, tx_busy_nxt;
	logic tx_is_boot_r, tx_is_boot_nxt;
	cno_frame_s tx_r, tx_nxt;
	logic emcy_sent;

	always_comb begin
		tx_busy_nxt = tx_busy_r;
		tx_is_boot_nxt = tx_is_boot_r;
		tx_nxt = tx_r;
		boot_sent = 1'b0;
		emcy_sent = 1'b0;
		if (tx_busy_r && tx_ready) begin
			tx_busy_nxt = 1'b0;
			boot_sent = tx_is_boot_r;
			emcy_sent = !tx_is_boot_r;
		end else if (!tx_busy_r && boot_pend_r) begin
			tx_busy_nxt = 1'b1;
			tx_is_boot_nxt = 1'b1;
			tx_nxt.id = cno_id(CNO_ID_ECTL, node_id_r); // RULE_16
			tx_nxt.dlc = CNO_DLC_ECTL;
			tx_nxt.data = {56'h0, CNO_ST_BOOT}; // RULE_24
		end else if (!tx_busy_r && emcy_pend_r && cno_emcy_ok(state_r)) begin
			tx_busy_nxt = 1'b1;
			tx_is_boot_nxt = 1'b0;
			tx_nxt.id = cno_id(CNO_ID_EMCY, node_id_r); // RULE_12
			tx_nxt.dlc = CNO_DLC_EMCY; // RULE_19
			tx_nxt.data = {err_vendor, err_reg, err_code[15:8], err_code[7:0]}; // RULE_20 RULE_21
		end
		// Set wins over the clear of the same cycle
		emcy_pend_nxt = err_change || (emcy_pend_r && !emcy_sent); // RULE_18
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			emcy_pend_r <= 1'b0;
			tx_busy_r <= 1'b0;
			tx_is_boot_r <= 1'b0;
			tx_r <= '0;
		end else if (ce) begin
			emcy_pend_r <= emcy_pend_nxt;
			tx_busy_r <= tx_busy_nxt;
			tx_is_boot_r <= tx_is_boot_nxt;
			tx_r <= tx_nxt;
		end
	end

	// ----------------------------------------
	// Transmit identifiers for PDO and SDO engines
	// ----------------------------------------
	logic [10:0] tpdo_base [4];
	logic [3:0][10:0] tpdo_id_nxt, tpdo_id_r;
	logic [10:0] sdo_tx_id_nxt, sdo_tx_id_r;

	assign tpdo_base[0] = CNO_ID_TPDO1;
	assign tpdo_base[1] = CNO_ID_TPDO2;
	assign tpdo_base[2] = CNO_ID_TPDO3;
	assign tpdo_base[3] = CNO_ID_TPDO4;

	// Follows the latched address, so it tracks each communication reset
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			tpdo_id_nxt[i] = cno_id(tpdo_base[i], node_id_nxt); // RULE_13
		end
		sdo_tx_id_nxt = cno_id(CNO_ID_SDO_TX, node_id_nxt); // RULE_15
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tpdo_id_r <= '0;
			sdo_tx_id_r <= 11'h000;
		end else if (ce) begin
			tpdo_id_r <= tpdo_id_nxt;
			sdo_tx_id_r <= sdo_tx_id_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign tx_valid = tx_busy_r;
	assign tx_frame = tx_r;
	assign tpdo_sync_trig = trig_r;
	assign rpdo_hit = rpdo_r;
	assign sdo_req_hit = sdo_r;
	assign pdo_en = pdo_en_r;
	assign sdo_en = sdo_en_r;
	assign app_rst = app_rst_r;
	assign comm_rst = comm_rst_r;
	assign nmt_state = st_byte_r;
	assign node_id = node_id_r;
	assign tpdo_id = tpdo_id_r;
	assign sdo_tx_id = sdo_tx_id_r;

endmodule : cno_nmt_node

// ### design/cno_pkg.sv
package cno_pkg;

	// ----------------------------------------
	// Identifiers
	// ----------------------------------------
	localparam logic [10:0] CNO_ID_NMT = 11'h000;
	localparam logic [10:0] CNO_ID_SYNC = 11'h080;
	localparam logic [10:0] CNO_ID_EMCY = 11'h080;
	localparam logic [10:0] CNO_ID_TPDO1 = 11'h180;
	localparam logic [10:0] CNO_ID_TPDO2 = 11'h280;
	localparam logic [10:0] CNO_ID_TPDO3 = 11'h380;
	localparam logic [10:0] CNO_ID_TPDO4 = 11'h480;
	localparam logic [10:0] CNO_ID_RPDO1 = 11'h200;
	localparam logic [10:0] CNO_ID_RPDO2 = 11'h300;
	localparam logic [10:0] CNO_ID_RPDO3 = 11'h400;
	localparam logic [10:0] CNO_ID_RPDO4 = 11'h500;
	localparam logic [10:0] CNO_ID_SDO_TX = 11'h580;
	localparam logic [10:0] CNO_ID_SDO_RX = 11'h600;
	localparam logic [10:0] CNO_ID_ECTL = 11'h700;
	localparam logic [10:0] CNO_FC_MASK = 11'h780;

	// ----------------------------------------
	// Commands, lengths, state bytes
	// ----------------------------------------
	localparam logic [7:0] CNO_CMD_START = 8'h01;
	localparam logic [7:0] CNO_CMD_STOP = 8'h02;
	localparam logic [7:0] CNO_CMD_PREOP = 8'h80;
	localparam logic [7:0] CNO_CMD_RST_NODE = 8'h81;
	localparam logic [7:0] CNO_CMD_RST_COMM = 8'h82;
	localparam logic [3:0] CNO_DLC_NMT = 4'h2;
	localparam logic [3:0] CNO_DLC_SYNC = 4'h0;
	localparam logic [3:0] CNO_DLC_EMCY = 4'h8;
	localparam logic [3:0] CNO_DLC_ECTL = 4'h1;
	localparam logic [7:0] CNO_ST_BOOT = 8'h00;
	localparam logic [7:0] CNO_ST_STOP = 8'h04;
	localparam logic [7:0] CNO_ST_OPER = 8'h05;
	localparam logic [7:0] CNO_ST_PREOP = 8'h7f;
	localparam logic [6:0] CNO_NODE_MIN = 7'h01;
	localparam logic [6:0] CNO_NODE_DEF = 7'h01;
	localparam logic [7:0] CNO_BCAST = 8'h00;

	// ----------------------------------------
	// Timing: reset pulse length
	// ----------------------------------------
	localparam int CNO_CLK_MHZ = 250;
	localparam int CNO_RST_PULSE_NS = 40;
	localparam logic [3:0] CNO_RST_CYC = 4'((CNO_RST_PULSE_NS * CNO_CLK_MHZ + 999) / 1000);

	typedef enum {
		CNO_INIT,
		CNO_BOOT,
		CNO_PREOP,
		CNO_OPER,
		CNO_STOPPED,
		CNO_RST_APP,
		CNO_RST_COMM
	} cno_state_e;

	typedef struct packed {
		logic [10:0] id;
		logic [3:0] dlc;
		logic [63:0] data;
	} cno_frame_s;

endpackage : cno_pkg

// ### testbench/cno_master_model.sv
`timescale 1ns/10ps
module cno_master_model
	import cno_pkg::*;
(
	input wire logic clk, // Clock
	output logic rx_valid, // Frame strobe
	output cno_frame_s rx_frame, // Frame to node
	output logic tx_ready, // Node frame taken
	input wire logic tx_valid, // Node frame pending
	input wire cno_frame_s tx_frame // Node frame
);
	int lat = 0;
	int wait_n = 0;
	int taken_n = 0;
	cno_frame_s last_tx = '0;
	initial begin
		rx_valid = 1'h0;
		rx_frame = '0;
		tx_ready = 1'h0;
	end
	task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [15:0] d);
		@(posedge clk);
		#1;
		rx_valid = 1'h1;
		rx_frame = {id, dlc, 48'h0, d};
		@(posedge clk);
		#1;
		rx_valid = 1'h0;
		rx_frame = ~rx_frame; // Idle bus shows the inverted last frame
	endtask : send
	// Slow acceptance when lat is above zero
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			last_tx = tx_frame;
			taken_n++;
		end
		wait_n = (tx_valid && !tx_ready) ? wait_n + 1 : 0;
		#1;
		tx_ready = tx_valid && wait_n >= lat;
	end
endmodule : cno_master_model

// ### testbench/cno_nmt_node_properties.sv
`timescale 1ns/10ps
module cno_nmt_node_properties
	import cno_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic ce, // Enable
	input wire logic rx_valid, // Rx strobe
	input wire cno_frame_s rx_frame, // Rx frame
	input wire logic tx_valid, // Tx pending
	input wire logic tx_ready, // Tx taken
	input wire cno_frame_s tx_frame, // Tx frame
	input wire logic [3:0] tpdo_sync, // Sync flags
	input wire logic [3:0] tpdo_sync_trig, // Sync pulses
	input wire logic [3:0] rpdo_hit, // Rx PDO pulses
	input wire logic pdo_en, // PDO open
	input wire logic sdo_en, // SDO open
	input wire logic [7:0] nmt_state, // State byte
	input wire logic [6:0] node_id // Address
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	emcy_len_a: assert property (
		tx_valid && tx_frame.id[10:7] == 4'h1 |-> tx_frame.dlc == CNO_DLC_EMCY)
		else $error("emergency length");
	tx_hold_a: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
		else $error("frame dropped");
	stop_gate_a: assert property (
		nmt_state == CNO_ST_STOP |-> !pdo_en && !sdo_en) else $error("stopped gate");
	pdo_gate_a: assert property (
		pdo_en |-> nmt_state == CNO_ST_OPER) else $error("pdo gate");
	preop_gate_a: assert property (
		nmt_state == CNO_ST_PREOP |-> sdo_en && !pdo_en) else $error("preop gate");
	start_cmd_a: assert property (
		rx_valid && ce && rx_frame.id == CNO_ID_NMT && rx_frame.dlc == CNO_DLC_NMT
		&& rx_frame.data[15:0] == 16'h0001 && (sdo_en || nmt_state == CNO_ST_STOP)
		|=> pdo_en) else $error("start ignored");
	rpdo_pulse_a: assert property (
		rx_valid && ce && pdo_en && rx_frame.id == (CNO_ID_RPDO1 | 11'(node_id))
		|-> ##[1:2] rpdo_hit[0]) else $error("rpdo missed");
	sync_trig_a: assert property (
		rx_valid && ce && pdo_en && rx_frame.id == CNO_ID_SYNC && rx_frame.dlc == 4'h0
		|-> ##[1:2] tpdo_sync_trig == tpdo_sync) else $error("sync trigger");
endmodule : cno_nmt_node_properties

// ### testbench/test_canopen_nmt_node_messaging.sv
`timescale 1ns/10ps
module test_canopen_nmt_node_messaging
	import cno_pkg::*;
;
	localparam logic [6:0] NODE = 7'h05;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic ce = 1'h1;
	logic err_change = 1'h0;
	logic [15:0] err_code = 16'h0;
	logic [7:0] err_reg = 8'h0;
	logic [39:0] err_vendor = 40'h0;
	logic [3:0] tpdo_sync = 4'ha;
	logic rx_valid, tx_valid, tx_ready, sdo_req_hit, pdo_en, sdo_en, app_rst, comm_rst;
	cno_frame_s rx_frame, tx_frame;
	logic [3:0] tpdo_sync_trig, rpdo_hit;
	logic [7:0] nmt_state;
	logic [6:0] node_id;
	logic [6:0] node_pin = NODE;
	logic [3:0][10:0] tpdo_id;
	logic [10:0] sdo_tx_id;
	logic [1:0] rst_seen;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	cno_nmt_node dut (.clk, .rst, .ce, .node_id_pin(node_pin), .rx_valid, .rx_frame, .tx_valid,
		.tx_ready, .tx_frame, .err_code, .err_reg, .err_vendor, .err_change, .tpdo_sync,
		.tpdo_sync_trig, .tpdo_id, .sdo_tx_id, .rpdo_hit, .sdo_req_hit, .pdo_en, .sdo_en,
		.app_rst, .comm_rst, .nmt_state, .node_id);
	cno_master_model mdl (.clk, .rx_valid, .rx_frame, .tx_ready, .tx_valid, .tx_frame);
	initial forever #2 clk = ~clk;
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			$display("[FAIL] cycle limit expected below %0d seen %0d", 5000, cyc);
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic st(input logic [7:0] s);
		chk("state", s, nmt_state);
		chk("pdo_en", s == CNO_ST_OPER, pdo_en);
		chk("sdo_en", s == CNO_ST_OPER || s == CNO_ST_PREOP, sdo_en);
	endtask : st
	// Waits for a node frame, then checks a boot-up frame if asked
	task automatic take(input int n0, input logic boot);
		for (int i = 0; i < 300 && mdl.taken_n == n0; i++) begin
			@(posedge clk);
			#2;
			rst_seen |= {app_rst, comm_rst};
		end
		chk("taken", 1'h1, mdl.taken_n > n0);
		if (boot) begin
			chk("boot id", CNO_ID_ECTL | 11'(NODE), mdl.last_tx.id);
			chk("boot dlc", CNO_DLC_ECTL, mdl.last_tx.dlc);
			chk("boot state", CNO_ST_BOOT, mdl.last_tx.data);
			@(posedge clk);
			#1;
			st(CNO_ST_PREOP);
		end
	endtask : take
	task automatic nmt(input logic [7:0] cmd, input logic [7:0] addr);
		mdl.send(CNO_ID_NMT, CNO_DLC_NMT, {addr, cmd});
		@(posedge clk);
		#1;
	endtask : nmt
	task automatic pulse(input logic [10:0] id, input logic [8:0] exp);
		logic [8:0] acc;
		acc = 9'h0;
		mdl.send(id, (id == CNO_ID_SYNC) ? CNO_DLC_SYNC : 4'h8, 16'h0);
		repeat (3) begin
			acc |= {tpdo_sync_trig, rpdo_hit, sdo_req_hit};
			@(posedge clk);
			#1;
		end
		chk("pulses", exp, acc);
	endtask : pulse
	task automatic t_nmt();
		logic [23:0] tbl [9] = '{24'h010505, 24'h020004, 24'h010005, 24'h80057f, 24'h020504,
			24'h80007f, 24'h01067f, 24'h55057f, 24'h010505};
		foreach (tbl[i]) begin
			nmt(tbl[i][23:16], tbl[i][15:8]);
			st(tbl[i][7:0]);
		end
		$display("nmt done");
	endtask : t_nmt
	task automatic t_traffic();
		for (int i = 0; i < 4; i++)
			pulse(11'h200 + 11'(i) * 11'h100 + 11'(NODE), 9'h002 << i);
		pulse(CNO_ID_SDO_RX + 11'(NODE), 9'h001);
		pulse(CNO_ID_SYNC, 9'h140);
		pulse(CNO_ID_RPDO1 + 11'h006, 9'h000);
		for (int i = 0; i < 4; i++)
			chk("tpdo id", 11'h180 + 11'(i) * 11'h100 + 11'(NODE), tpdo_id[i]);
		chk("sdo tx id", CNO_ID_SDO_TX + 11'(NODE), sdo_tx_id);
		nmt(CNO_CMD_STOP, 8'h05);
		pulse(CNO_ID_SDO_RX + 11'(NODE), 9'h000);
		pulse(CNO_ID_SYNC, 9'h000);
		nmt(CNO_CMD_PREOP, 8'h05);
		pulse(CNO_ID_RPDO1 + 11'(NODE), 9'h000);
		pulse(CNO_ID_SDO_RX + 11'(NODE), 9'h001);
		mdl.send(CNO_ID_NMT, 4'h3, {8'h05, CNO_CMD_STOP});
		@(posedge clk);
		#1;
		st(CNO_ST_PREOP);
		nmt(CNO_CMD_START, 8'h00);
		$display("traffic done");
	endtask : t_traffic
	task automatic t_emcy();
		mdl.lat = 3;
		for (int i = 0; i < 2; i++) begin
			err_code = i ? 16'h0 : 16'h1234;
			err_reg = i ? 8'h0 : 8'h81;
			err_vendor = 40'h0102030405 + 40'(i);
			err_change = 1'h1;
			@(posedge clk);
			#1;
			err_change = 1'h0;
			take(mdl.taken_n, 1'h0);
			chk("emcy head", {CNO_ID_EMCY | 11'(NODE), 4'h8}, {mdl.last_tx.id, mdl.last_tx.dlc});
			chk("emcy data", {err_vendor, err_reg, err_code}, mdl.last_tx.data);
		end
		mdl.lat = 0;
		$display("emcy done");
	endtask : t_emcy
	task automatic t_reset();
		for (int i = 0; i < 2; i++) begin
			if (i)
				nmt(CNO_CMD_STOP, 8'h05);
			rst_seen = 2'h0;
			nmt(i ? CNO_CMD_RST_NODE : CNO_CMD_RST_COMM, i ? 8'h00 : 8'h05);
			take(mdl.taken_n, 1'h1);
			chk("reset phases", i ? 2'h3 : 2'h1, rst_seen);
		end
		node_pin = 7'h00;
		nmt(CNO_CMD_RST_COMM, 8'h05);
		take(mdl.taken_n, 1'h0);
		chk("clamped boot id", CNO_ID_ECTL | 11'h001, mdl.last_tx.id);
		chk("clamped node", 7'h01, node_id);
		chk("clamped tpdo", CNO_ID_TPDO1 | 11'h001, tpdo_id[0]);
		$display("reset done");
	endtask : t_reset
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 1'h0;
		take(0, 1'h1);
		$display("boot done");
		t_nmt();
		t_traffic();
		t_emcy();
		t_reset();
		print_verdict();
	end
endmodule : test_canopen_nmt_node_messaging
bind cno_nmt_node cno_nmt_node_properties u_props (.clk, .rst, .ce, .rx_valid, .rx_frame,
	.tx_valid, .tx_ready, .tx_frame, .tpdo_sync, .tpdo_sync_trig, .rpdo_hit, .pdo_en, .sdo_en,
	.nmt_state, .node_id);
